// ### rdpms_map.svh
`ifndef RDPMS_MAP_SVH
`define RDPMS_MAP_SVH

// Clock-source output divided by this to form the peripheral bus clock
`define RDPMS_BUS_DIV 2
// Bus cycles in one bit of the single-wire debug link
`define RDPMS_BIT_BUS_CYCLES 16
// Bus cycle inside a bit at which the line is sampled
`define RDPMS_SAMPLE_CYCLE 4'ha
// Bus cycle at which a transmitted zero is released (speed-up pulse)
`define RDPMS_ZERO_RELEASE 4'hd
// Bus cycle of the speed-up pulse for a transmitted one
`define RDPMS_ONE_SPEEDUP 4'h4
// Last bus cycle of a bit
`define RDPMS_LAST_CYCLE 4'hf
// Ref clock cycles in one bit, for checks
`define RDPMS_BIT_REF_CYCLES (`RDPMS_BIT_BUS_CYCLES * `RDPMS_BUS_DIV)
// Code fetch address on entry to run mode
`define RDPMS_RESET_FETCH_ADDR 16'h3ffd
// Reset values of the system option bits
`define RDPMS_RESET_PIN_ENABLE_RST 1'h0
`define RDPMS_DEBUG_PIN_ENABLE_RST 1'h1

`endif

// ### rdpms_pkg.sv
package rdpms_pkg;

  // Bit engine of the single-wire debug link
  typedef enum logic [1:0]
  {
    RDPMS_BIT_IDLE = 2'b00,
    RDPMS_BIT_RUN = 2'b01,
    RDPMS_BIT_WAIT_HIGH = 2'b10
  } rdpms_bit_state_e;

  typedef logic [3:0] rdpms_bit_cnt_t;

endpackage : rdpms_pkg

// ### rdpms_sync.sv
// Two-stage synchroniser for asynchronous pin levels
module rdpms_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  initial
  begin
    if (WIDTH < 1)
      $error("rdpms_sync: WIDTH must be at least 1");
  end

  // First stage is read only by the second stage; keeps running in reset
  // so that the mode select level is seen while srst is high
  always_ff @(posedge ref_clk)
  begin
    meta <= async_in;
    sync_out <= meta;
  end

endmodule : rdpms_sync

// ### rdpms_pin_mux.sv
// Functional notes
// [RULE1] After power-on reset the line five pin is a plain input port bit.
// [RULE2] Setting reset_pin_enable makes line five the reset input until reset.
// [RULE3] Line five low while acting as reset input resets the whole device.
// [RULE4] reset_pin_enable set forces the line five pullup on.
// [RULE5] As a port bit, line five is input only, never driven.
// [RULE6] As a port bit, line four is output only, no input path.
// [RULE7] During power-on or forced debug reset the debug line selects mode.
// [RULE8] After any reset release the debug line is the debug pin.
// [RULE9] Pullup stays on while the line is debug or mode select.
// [RULE10] debug_pin_enable set by every reset; cleared by software for port use.
// [RULE11] Debug line high at reset release enters run mode.
// [RULE12] Host holds debug line low at reset to enter background mode.
// [RULE13] Each debug link bit lasts sixteen debug controller clocks.
// [RULE14] Debug controller clock equals the peripheral bus clock rate.
// [RULE15] Debug line is pseudo open-drain with brief driven-high speed-ups.
// [RULE16] Bus clock is clock-source output divided by two, for all modules.
// [RULE17] Run mode starts fetching code at the top-of-memory reset location.
// [RULE18] Other shared pins reset to plain inputs with pulls disabled.
// [RULE19] Once set, reset_pin_enable ignores clearing writes until reset.
// [RULE20] Debug line is synchronised before mode sampling or bit reception.
`include "rdpms_map.svh"

module rdpms_pin_mux
  import rdpms_pkg::*;
#(
  parameter int OTHER_PINS = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic por_reset,
  input wire logic forced_debug_reset,
  input wire logic sys_opt_wr,
  input wire logic sys_opt_reset_pin_enable,
  input wire logic sys_opt_debug_pin_enable,
  input wire logic port_five_pullup_cfg,
  input wire logic port_four_data,
  input wire logic port_four_sel_comparator,
  input wire logic comparator_output,
  input wire logic other_cfg_wr,
  input wire logic [OTHER_PINS-1:0] other_dir_cfg,
  input wire logic [OTHER_PINS-1:0] other_pull_cfg,
  input wire logic tx_arm,
  input wire logic tx_bit,
  input wire logic port_a_line_five_in,
  input wire logic debug_line_in,
  output logic port_a_line_five_oe,
  output logic port_a_line_five_pullup_en,
  output logic port_a_line_five_data,
  output logic ext_reset_req,
  output logic reset_pin_enable,
  output logic debug_pin_enable,
  output logic debug_line_out,
  output logic debug_line_oe,
  output logic debug_line_pullup_en,
  output logic bus_clk_en,
  output logic run_mode,
  output logic background_mode,
  output logic [15:0] fetch_addr,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic tx_busy,
  output logic [OTHER_PINS-1:0] other_dir_out,
  output logic [OTHER_PINS-1:0] other_pull_en
);

  logic five_s;
  logic dbg_s;
  logic dbg_prev;
  logic srst_q;
  logic mode_kind;
  logic mode_level;
  logic tx_pending;
  logic tx_val;
  logic next_drive_low;
  logic next_speedup;
  rdpms_bit_state_e bit_state;
  rdpms_bit_cnt_t bit_cnt;
  logic [5:0] span_cnt;

  initial
  begin
    if (OTHER_PINS < 1 || OTHER_PINS > 64)
      $error("rdpms_pin_mux: OTHER_PINS must be 1 to 64");
  end

  // Pin levels brought into the clock domain
  rdpms_sync #(.WIDTH(2)) u_pin_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in({port_a_line_five_in, debug_line_in}),
    .sync_out({five_s, dbg_s}) // [RULE20]
  );

  // Bus clock enable: every second ref clock
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      bus_clk_en <= 1'h0;
    else
      bus_clk_en <= ~bus_clk_en; // [RULE16] [RULE14]
  end

  // System option bits
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      reset_pin_enable <= `RDPMS_RESET_PIN_ENABLE_RST; // [RULE1]
      debug_pin_enable <= `RDPMS_DEBUG_PIN_ENABLE_RST; // [RULE10]
    end
    else if (sys_opt_wr)
    begin
      // reset_pin_enable set only; clearing waits for the next reset
      reset_pin_enable <= reset_pin_enable | sys_opt_reset_pin_enable; // [RULE2] [RULE19]
      debug_pin_enable <= sys_opt_debug_pin_enable; // [RULE10]
    end
  end

  // Line five: input port bit or external reset input
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      port_a_line_five_oe <= 1'h0;
      port_a_line_five_pullup_en <= 1'h0;
      port_a_line_five_data <= 1'h0;
      ext_reset_req <= 1'h0;
    end
    else
    begin
      port_a_line_five_oe <= 1'h0; // [RULE5]
      port_a_line_five_pullup_en <= reset_pin_enable | port_five_pullup_cfg; // [RULE4]
      port_a_line_five_data <= reset_pin_enable ? 1'h0 : five_s; // [RULE1]
      ext_reset_req <= reset_pin_enable & ~five_s; // [RULE3]
    end
  end

  // Mode select sampled during power-on or forced debug reset
  always_ff @(posedge ref_clk)
  begin
    srst_q <= srst;
    if (srst)
    begin
      mode_kind <= por_reset | forced_debug_reset; // [RULE7]
      mode_level <= dbg_s; // [RULE7] [RULE12]
    end
  end

  // Operating mode and fetch address decided at reset release
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      run_mode <= 1'h0;
      background_mode <= 1'h0;
      fetch_addr <= 16'h0000;
    end
    else if (srst_q)
    begin
      run_mode <= ~mode_kind | mode_level; // [RULE11]
      background_mode <= mode_kind & ~mode_level; // [RULE12]
      fetch_addr <= `RDPMS_RESET_FETCH_ADDR; // [RULE17]
    end
  end

  // Other shared pins: inputs, pulls off, until configured
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      other_dir_out <= '0; // [RULE18]
      other_pull_en <= '0; // [RULE18]
    end
    else if (other_cfg_wr)
    begin
      other_dir_out <= other_dir_cfg;
      other_pull_en <= other_pull_cfg;
    end
  end

  // Transmit bit waits for the next host-started bit
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      tx_pending <= 1'h0;
      tx_val <= 1'h0;
    end
    else if (tx_arm && !tx_pending)
    begin
      tx_pending <= 1'h1;
      tx_val <= tx_bit;
    end
    else if (bit_state == RDPMS_BIT_RUN && bus_clk_en &&
             bit_cnt == `RDPMS_LAST_CYCLE)
      tx_pending <= 1'h0;
  end

  // Bit engine counts bus cycles from the host falling edge
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      // Line held low across release must not look like a falling edge
      dbg_prev <= dbg_s;
      bit_state <= RDPMS_BIT_IDLE;
      bit_cnt <= 4'h0;
      rx_bit_valid <= 1'h0;
      rx_bit <= 1'h0;
    end
    else
    begin
      dbg_prev <= dbg_s;
      rx_bit_valid <= 1'h0;
      case (bit_state)
        RDPMS_BIT_IDLE:
        begin
          bit_cnt <= 4'h0;
          if (debug_pin_enable && dbg_prev && !dbg_s) // [RULE8]
            bit_state <= RDPMS_BIT_RUN;
        end
        RDPMS_BIT_RUN:
        begin
          if (bus_clk_en)
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `RDPMS_SAMPLE_CYCLE && !tx_pending)
            begin
              rx_bit_valid <= 1'h1;
              rx_bit <= dbg_s;
            end
            if (bit_cnt == `RDPMS_LAST_CYCLE)
              bit_state <= RDPMS_BIT_WAIT_HIGH; // [RULE13]
          end
        end
        RDPMS_BIT_WAIT_HIGH:
        begin
          bit_cnt <= 4'h0;
          if (dbg_s)
            bit_state <= RDPMS_BIT_IDLE;
        end
        default:
          bit_state <= RDPMS_BIT_IDLE;
      endcase
    end
  end

  // Drive decisions for a transmitted bit
  always_comb
  begin
    next_drive_low = bit_state == RDPMS_BIT_RUN && tx_pending && !tx_val &&
                     bit_cnt < `RDPMS_ZERO_RELEASE;
    next_speedup = bit_state == RDPMS_BIT_RUN && tx_pending &&
                   bit_cnt == (tx_val ? `RDPMS_ONE_SPEEDUP :
                               `RDPMS_ZERO_RELEASE);
  end

  // Debug line: mode input in reset, pseudo open-drain, or port output
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      debug_line_out <= 1'h1;
      debug_line_oe <= 1'h0; // [RULE7]
      debug_line_pullup_en <= 1'h1; // [RULE9]
      tx_busy <= 1'h0;
    end
    else
    begin
      tx_busy <= tx_pending;
      debug_line_pullup_en <= debug_pin_enable; // [RULE9]
      if (debug_pin_enable)
      begin
        debug_line_out <= ~next_drive_low; // [RULE15]
        debug_line_oe <= next_drive_low | next_speedup; // [RULE15]
      end
      else
      begin
        // Output only; no input path in port use
        debug_line_out <= port_four_sel_comparator ? comparator_output :
                          port_four_data; // [RULE6] [RULE10]
        debug_line_oe <= 1'h1; // [RULE6]
      end
    end
  end

  // Ref clock cycles spent in one bit
  always_ff @(posedge ref_clk)
  begin
    if (srst || bit_state != RDPMS_BIT_RUN)
      span_cnt <= 6'h00;
    else
      span_cnt <= span_cnt + 6'h01;
  end

  AST_LINE_FIVE_NOT_DRIVEN: assert property ( // [RULE5]
    @(posedge ref_clk) disable iff (srst) !port_a_line_five_oe)
    else $error("line five driven");

  AST_RESET_PIN_STICKY: assert property ( // [RULE2] [RULE19]
    @(posedge ref_clk) disable iff (srst)
    reset_pin_enable |=> reset_pin_enable)
    else $error("reset pin enable cleared without reset");

  AST_EXT_RESET: assert property ( // [RULE3]
    @(posedge ref_clk) disable iff (srst)
    reset_pin_enable && !five_s |=> ext_reset_req)
    else $error("external reset not forwarded");

  AST_FIVE_PULLUP: assert property ( // [RULE4]
    @(posedge ref_clk) disable iff (srst)
    reset_pin_enable |=> port_a_line_five_pullup_en)
    else $error("line five pullup off in reset mode");

  AST_DEBUG_PULLUP: assert property ( // [RULE9]
    @(posedge ref_clk) disable iff (srst)
    debug_pin_enable |=> debug_line_pullup_en)
    else $error("debug pullup off");

  AST_DPE_AFTER_RESET: assert property ( // [RULE10]
    @(posedge ref_clk) srst ##1 !srst |-> debug_pin_enable && !debug_line_oe)
    else $error("debug pin enable not set by reset");

  AST_RUN_MODE: assert property ( // [RULE11]
    @(posedge ref_clk) disable iff (srst)
    srst_q && (mode_level || !mode_kind) |=> run_mode && !background_mode)
    else $error("run mode not entered");

  AST_BUS_DIV: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (srst)
    bus_clk_en |=> !bus_clk_en ##1 bus_clk_en)
    else $error("bus clock enable not divide by two");

  AST_BIT_SPAN: assert property ( // [RULE13]
    @(posedge ref_clk) disable iff (srst)
    $fell(bit_state == RDPMS_BIT_RUN) |->
    $past(span_cnt) >= 6'(`RDPMS_BIT_REF_CYCLES - 2) &&
    $past(span_cnt) <= 6'(`RDPMS_BIT_REF_CYCLES - 1))
    else $error("debug bit length wrong");

  AST_ZERO_SPEEDUP: assert property ( // [RULE15]
    @(posedge ref_clk) disable iff (srst)
    debug_pin_enable && debug_line_oe && debug_line_out |=>
    !debug_pin_enable || !debug_line_oe || debug_line_out)
    else $error("speed-up pulse malformed");

endmodule : rdpms_pin_mux

// ### rdpms_host_model.sv
// Far side of the pins: debug host or external reset source
module rdpms_host_model (
  input wire logic ref_clk,
  input wire logic debug_line_oe,
  input wire logic debug_line_out,
  input wire logic debug_line_pullup_en,
  input wire logic host_low,
  input wire logic port_a_line_five_pullup_en,
  input wire logic src_low,
  output logic debug_line_lvl,
  output logic line_five_lvl
);
  logic flip = 1'b0;

  // Undriven line without pullup wanders every cycle
  always @(posedge ref_clk)
  begin
    flip <= ~flip;
  end

  // Pseudo open-drain debug line, host may pull low in or after reset
  assign debug_line_lvl = debug_line_oe ? debug_line_out :
    host_low ? 1'b0 : debug_line_pullup_en ? 1'b1 : flip;

  // Reset source only ever pulls line five low
  assign line_five_lvl = src_low ? 1'b0 :
    port_a_line_five_pullup_en ? 1'b1 : flip;
endmodule : rdpms_host_model

// ### tb_reset_debug_pin_mode_select.sv
`include "rdpms_map.svh"
module tb_reset_debug_pin_mode_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, srst = 1'b1, por_reset = 1'b1, fdr = 1'b0;
  logic sys_opt_wr = 1'b0, rpe_d = 1'b0, dpe_d = 1'b0, p5_pu = 1'b0;
  logic p4_d = 1'b0, p4_sel = 1'b0, cmp = 1'b0, oth_wr = 1'b0;
  logic tx_arm = 1'b0, tx_bit = 1'b0, host_low = 1'b0, src_low = 1'b0;
  logic [15:0] oth_dir = 16'h0000, oth_pull = 16'h0000;
  logic l5_in, dbg_in, l5_oe, l5_pu, l5_data, ext_reset_req, b;
  logic reset_pin_enable, debug_pin_enable, dbg_out, dbg_oe, dbg_pu;
  logic bus_clk_en, run_mode, background_mode, rx_bit_valid, rx_bit;
  logic tx_busy;
  logic [15:0] fetch_addr, other_dir_out, other_pull_en;
  int fails = 0, checked = 0, cyc = 0;

  // Free-running reference clock
  always #4 ref_clk = ~ref_clk;

  rdpms_pin_mux DUT (.ref_clk(ref_clk), .srst(srst), .por_reset(por_reset),
    .forced_debug_reset(fdr), .sys_opt_wr(sys_opt_wr),
    .sys_opt_reset_pin_enable(rpe_d), .sys_opt_debug_pin_enable(dpe_d),
    .port_five_pullup_cfg(p5_pu), .port_four_data(p4_d),
    .port_four_sel_comparator(p4_sel), .comparator_output(cmp),
    .other_cfg_wr(oth_wr), .other_dir_cfg(oth_dir),
    .other_pull_cfg(oth_pull), .tx_arm(tx_arm), .tx_bit(tx_bit),
    .port_a_line_five_in(l5_in), .debug_line_in(dbg_in),
    .port_a_line_five_oe(l5_oe), .port_a_line_five_pullup_en(l5_pu),
    .port_a_line_five_data(l5_data), .ext_reset_req(ext_reset_req),
    .reset_pin_enable(reset_pin_enable), .debug_pin_enable(debug_pin_enable),
    .debug_line_out(dbg_out), .debug_line_oe(dbg_oe),
    .debug_line_pullup_en(dbg_pu), .bus_clk_en(bus_clk_en),
    .run_mode(run_mode), .background_mode(background_mode),
    .fetch_addr(fetch_addr), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .tx_busy(tx_busy), .other_dir_out(other_dir_out),
    .other_pull_en(other_pull_en));

  rdpms_host_model host (.ref_clk(ref_clk), .debug_line_oe(dbg_oe),
    .debug_line_out(dbg_out), .debug_line_pullup_en(dbg_pu),
    .host_low(host_low), .port_a_line_five_pullup_en(l5_pu),
    .src_low(src_low), .debug_line_lvl(dbg_in), .line_five_lvl(l5_in));

  task complete_run;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task clk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : clk

  task rst(input logic p, input logic f, input logic h);
    @(negedge ref_clk);
    srst = 1'b1;
    por_reset = p;
    fdr = f;
    host_low = h;
    clk(7);
    chk({dbg_oe, dbg_pu, debug_pin_enable}, 3'h3);
    clk(1);
    srst = 1'b0;
    por_reset = 1'b0;
    fdr = 1'b0;
    clk(3);
    host_low = 1'b0;
    clk(4);
  endtask : rst

  task wopt(input logic r, input logic d);
    @(negedge ref_clk);
    sys_opt_wr = 1'b1;
    rpe_d = r;
    dpe_d = d;
    clk(1);
    sys_opt_wr = 1'b0;
    clk(2);
  endtask : wopt

  // Host sends one bit: short low for a one, long low for a zero
  task hbit(input logic v);
    logic seen;
    seen = 1'b0;
    host_low = 1'b1;
    for (int n = 0; n < 70; n++)
    begin
      clk(1);
      if (n == (v ? 6 : 28))
        host_low = 1'b0;
      if (rx_bit_valid === 1'b1)
      begin
        seen = 1'b1;
        chk(rx_bit, v);
      end
    end
    chk(seen, 1'b1);
  endtask : hbit

  // Device answers one host-started bit with an armed value
  task txb(input logic v);
    int hi;
    hi = 0;
    @(negedge ref_clk);
    tx_arm = 1'b1;
    tx_bit = v;
    clk(1);
    tx_arm = 1'b0;
    clk(1);
    chk(tx_busy, 1'b1);
    host_low = 1'b1;
    for (int n = 0; n < 70; n++)
    begin
      clk(1);
      if (n == 6)
        host_low = 1'b0;
      if (n == 12 && !v)
        chk({dbg_oe, dbg_out}, 2'h2);
      if (dbg_oe === 1'b1 && dbg_out === 1'b1)
        hi++;
    end
    chk({tx_busy, dbg_oe}, 2'h0);
    chk(16'(hi), `RDPMS_BUS_DIV);
  endtask : txb

  // Cut a hung run short
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fails++;
      complete_run;
    end
  end

  // Main test sequence
  initial
  begin
    rst(1'b1, 1'b0, 1'b0);
    chk({run_mode, background_mode}, 2'h2);
    chk(fetch_addr, `RDPMS_RESET_FETCH_ADDR);
    chk({reset_pin_enable, debug_pin_enable}, 2'h1);
    chk(other_dir_out | other_pull_en, 16'h0000);
    b = bus_clk_en;
    clk(1);
    chk(bus_clk_en, !b);
    clk(1);
    chk(bus_clk_en, b);
    src_low = 1'b1;
    clk(4);
    chk({l5_data, ext_reset_req, l5_oe}, 3'h0);
    p5_pu = 1'b1;
    src_low = 1'b0;
    clk(4);
    chk({l5_data, l5_pu}, 2'h3);
    p5_pu = 1'b0;
    wopt(1'b1, 1'b1);
    chk({reset_pin_enable, l5_pu}, 2'h3);
    wopt(1'b0, 1'b1);
    chk(reset_pin_enable, 1'b1);
    src_low = 1'b1;
    clk(4);
    chk({ext_reset_req, l5_oe}, 2'h2);
    src_low = 1'b0;
    clk(4);
    chk(ext_reset_req, 1'b0);
    oth_dir = 16'h5a3c;
    oth_pull = 16'h00ff;
    oth_wr = 1'b1;
    clk(1);
    oth_wr = 1'b0;
    clk(2);
    chk(other_dir_out ^ other_pull_en, 16'h5ac3);
    rst(1'b0, 1'b1, 1'b1);
    chk({reset_pin_enable, run_mode, background_mode}, 3'h1);
    chk(other_dir_out | other_pull_en, 16'h0000);
    hbit(1'b0);
    hbit(1'b1);
    txb(1'b0);
    txb(1'b1);
    wopt(1'b0, 1'b0);
    p4_d = 1'b1;
    clk(2);
    chk({dbg_oe, dbg_out}, 2'h3);
    p4_d = 1'b0;
    clk(2);
    chk({dbg_oe, dbg_out}, 2'h2);
    p4_sel = 1'b1;
    cmp = 1'b1;
    clk(2);
    chk({dbg_oe, dbg_out}, 2'h3);
    rst(1'b0, 1'b0, 1'b0);
    chk({debug_pin_enable, run_mode}, 2'h3);
    complete_run;
  end
endmodule : tb_reset_debug_pin_mode_select
